// ---- logic/riox_pkg.sv ----
// Package of constants and types for the return/option execution block
package riox_pkg;
  localparam logic [13:0] RIOX_OP_RETURN_FROM_INTERRUPT = 14'h0009; // Return from interrupt word
  localparam logic [13:0] RIOX_OP_OPTION_LOAD           = 14'h0062; // Legacy option load word
  localparam int          RIOX_GIE_BIT                  = 7;        // Enable bit in interrupt control
  localparam logic [7:0]  RIOX_OPTION_RESET             = 8'hFF;    // Option register after reset
  localparam logic [7:0]  RIOX_INTERRUPT_CONTROL_REG_RESET             = 8'h00;    // Interrupt control after reset
  localparam logic [12:0] RIOX_PC_RESET                 = 13'h0000; // Program counter after reset
  localparam logic [1:0]  RIOX_Q1                       = 2'h0;     // Phase codes
  localparam logic [1:0]  RIOX_Q2                       = 2'h1;
  localparam logic [1:0]  RIOX_Q3                       = 2'h2;
  localparam logic [1:0]  RIOX_Q4                       = 2'h3;
  localparam int          RIOX_RESET_SYNC_STAGES        = 2;        // Reset release flops

  // Execution state
  typedef enum logic [1:0] {
    RIOX_IDLE    = 2'b00,
    RIOX_RET_C1  = 2'b01,
    RIOX_RET_C2  = 2'b10,
    RIOX_OPT_C1  = 2'b11
  } riox_state_t;
endpackage

// ---- logic/riox_phase.sv ----
// Four-phase generator producing one-cycle phase enables
`timescale 1ns/1ps
module riox_phase
  import riox_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_sync_n,
  output logic [1:0]      phase,
  output logic            q1_en,
  output logic            q3_en,
  output logic            q4_en
);
  // Phase counter
  typedef struct packed {
    logic [1:0] ph;
  } riox_ph_t;

  riox_ph_t cur;   // Registered state
  riox_ph_t nxt;   // Next state

  // Advance one phase per clock
  always_comb begin
    nxt    = cur;
    nxt.ph = cur.ph + 2'h1;
  end

  // Register the phase
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cur.ph <= RIOX_Q1;
    end else begin
      cur <= nxt;
    end
  end

  assign phase = cur.ph;
  assign q1_en = (cur.ph == RIOX_Q1);
  assign q3_en = (cur.ph == RIOX_Q3);
  assign q4_en = (cur.ph == RIOX_Q4);
endmodule

// ---- logic/riox_exec.sv ----
// Execution of return-from-interrupt and the legacy option load
`timescale 1ns/1ps
// How it works
// - Return word pops stack into PC
// - Return sets global_irq_enable, bit seven
// - Return takes two cycles, second idle
// - Option word copies accumulator, one cycle
// - Keep decoding legacy option load
// - Option register also file-register addressable
module riox_exec
  import riox_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [13:0] instr_word,
  input  wire logic        instr_valid,
  input  wire logic [7:0]  accumulator,
  input  wire logic [12:0] return_stack_head,
  input  wire logic        file_opt_we,
  input  wire logic [7:0]  file_opt_wdata,
  input  wire logic        file_interrupt_control_reg_we,
  input  wire logic [7:0]  file_interrupt_control_reg_wdata,
  output logic             stack_pop,
  output logic             pc_load,
  output logic [12:0]      pc_value,
  output logic [7:0]       option_reg,
  output logic [7:0]       interrupt_control_reg,
  output logic             global_irq_enable,
  output logic             fetch_flush,
  output logic             instr_busy,
  output logic             status_we
);
  // Timing overview, counted in clocks from the decode edge
  // Decode happens only on the edge where the phase is Q1
  // A return raises busy on the decode edge itself
  // The enable bit is set on the Q3 edge of the first cycle
  // Pop, PC load and flush pulse after the Q4 edge
  // The second cycle of a return does nothing on purpose
  // That idle cycle lets the fetch path refill from the new PC
  // Busy drops after the Q4 edge of the second cycle
  // An option load copies the accumulator on its Q4 edge
  // Words that match neither opcode are simply ignored
  // Words arriving while a return is busy are ignored too
  // No arithmetic status flag is ever written by this block
  // File writes may arrive in any cycle, any phase
  // Instruction updates win over a file write in the same cycle
  // Hazard: a clear of the enable bit in Q3 is overridden
  // Whole state of the block
  typedef struct packed {
    riox_state_t st;
    logic        pop;
    logic        pcl;
    logic [12:0] pcv;
    logic [7:0]  opt;
    logic [7:0]  icr;
    logic        flush;
    logic        busy;
  } riox_reg_t;

  riox_reg_t   cur;          // Registered state
  riox_reg_t   nxt;          // Next state
  logic [1:0]  rst_sync;     // Reset release chain
  logic        rst_sync_n;   // Synchronised reset
  logic [1:0]  phase;        // Current phase
  logic        q1_en;        // Decode phase
  logic        q3_en;        // Third phase
  logic        q4_en;        // Fourth phase

  // Exact compare of the full fourteen-bit word
  // Partial decoding would let unrelated words trigger a return
  // Kept as a function so both opcodes use one comparator form
  // Decode helper shared by both instruction matches
  function automatic logic riox_match(input logic [13:0] w, input logic [13:0] op);
    riox_match = (w == op);
  endfunction

  // Reset asserts at once but releases on a clock edge
  // Avoids part of the state leaving reset a cycle before the rest
  // Every other flop in the block uses the synchronised copy
  // The phase counter restarts at Q1 on release
  // Reset released through two flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_sync[1];

  // Four clocks form one instruction cycle
  // Phase enables are single-clock pulses from the counter
  // Only Q1, Q3 and Q4 matter for these two instructions
  // Phase generator
  riox_phase u_phase (
    .core_clk   (core_clk),
    .rst_sync_n (rst_sync_n),
    .phase      (phase),
    .q1_en      (q1_en),
    .q3_en      (q3_en),
    .q4_en      (q4_en)
  );

  // Pulses default low so each lasts exactly one clock
  // Registers default to hold their value
  // File writes are applied first, instruction effects after
  // Later assignments therefore take priority in one cycle
  // Decoding is blocked outside the idle state
  // Returns walk two states, option load walks one
  // Next-state logic
  always_comb begin
    nxt       = cur;
    nxt.pop   = 1'b0;
    nxt.pcl   = 1'b0;
    nxt.flush = 1'b0;
    // File-register writes to the option register
    if (file_opt_we) begin
      nxt.opt = file_opt_wdata;
    end
    // File-register writes to interrupt control
    if (file_interrupt_control_reg_we) begin
      nxt.icr = file_interrupt_control_reg_wdata;
    end
    case (cur.st)
      RIOX_IDLE: begin
        // Decode in Q1
        if (q1_en && instr_valid) begin
          if (riox_match(instr_word, RIOX_OP_RETURN_FROM_INTERRUPT)) begin
            nxt.st   = RIOX_RET_C1;
            nxt.busy = 1'b1;
          end else if (riox_match(instr_word, RIOX_OP_OPTION_LOAD)) begin
            nxt.st = RIOX_OPT_C1;
          end
        end
      end
      RIOX_RET_C1: begin
        // Set enable in Q3, instruction wins over file write
        if (q3_en) begin
          nxt.icr[RIOX_GIE_BIT] = 1'b1;
        end
        // Pop and load PC in Q4
        if (q4_en) begin
          nxt.pop   = 1'b1;
          nxt.pcl   = 1'b1;
          nxt.pcv   = return_stack_head;
          nxt.flush = 1'b1;
          nxt.st    = RIOX_RET_C2;
        end
      end
      RIOX_RET_C2: begin
        // Whole idle cycle while fetch refills
        if (q4_en) begin
          nxt.st   = RIOX_IDLE;
          nxt.busy = 1'b0;
        end
      end
      RIOX_OPT_C1: begin
        // Copy accumulator at end of the single cycle
        if (q4_en) begin
          nxt.opt = accumulator;
          nxt.st  = RIOX_IDLE;
        end
      end
      default: begin
        nxt.st = RIOX_IDLE;
      end
    endcase
  end

  // Reset values are constants from the package
  // Option register resets to all ones
  // Interrupt control resets with interrupts disabled
  // State register
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cur.st    <= RIOX_IDLE;
      cur.pop   <= 1'b0;
      cur.pcl   <= 1'b0;
      cur.pcv   <= RIOX_PC_RESET;
      cur.opt   <= RIOX_OPTION_RESET;
      cur.icr   <= RIOX_INTERRUPT_CONTROL_REG_RESET;
      cur.flush <= 1'b0;
      cur.busy  <= 1'b0;
    end else begin
      cur <= nxt;
    end
  end

  // Every output except status_we is a field of the registered state
  // No combinational path from inputs to outputs
  // Status write strobe is tied off, flags untouched
  // Outputs straight from flops
  assign stack_pop             = cur.pop;
  assign pc_load               = cur.pcl;
  assign pc_value              = cur.pcv;
  assign option_reg            = cur.opt;
  assign interrupt_control_reg = cur.icr;
  assign global_irq_enable     = cur.icr[RIOX_GIE_BIT];
  assign fetch_flush           = cur.flush;
  assign instr_busy            = cur.busy;
  assign status_we             = 1'b0;
endmodule

// ---- bench/riox_exec_chk.sv ----
// Checker of the return/option execution block ports
`timescale 1ns/1ps
module riox_chk (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [12:0] return_stack_head,
  input wire logic        stack_pop,
  input wire logic        pc_load,
  input wire logic [12:0] pc_value,
  input wire logic [7:0]  interrupt_control_reg,
  input wire logic        global_irq_enable,
  input wire logic        fetch_flush,
  input wire logic        instr_busy,
  input wire logic        status_we
);
  // One clock domain, reset disables all
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Pop, load and flush travel together
  a_pop_load_pair: assert property (stack_pop |-> pc_load && fetch_flush) else $error("pop without load");
  a_pc_from_head: assert property (pc_load |-> pc_value == $past(return_stack_head)) else $error("bad pc");
  a_pop_one_clk: assert property (stack_pop |=> !stack_pop) else $error("pop too long");
  a_enable_bit_seven: assert property (global_irq_enable == interrupt_control_reg[7]) else $error("bit 7");
  a_enable_before_pop: assert property (stack_pop |-> $past(global_irq_enable)) else $error("enable late");
  a_busy_second_cycle: assert property ($rose(stack_pop) |-> instr_busy[*4] ##1 !instr_busy) else $error("span");
  a_phase_order: assert property ($rose(instr_busy) |-> ##2 global_irq_enable ##1 stack_pop) else $error("order");
  a_status_quiet: assert property (!status_we) else $error("status written");
endmodule
bind riox_exec riox_chk u_riox_chk (.core_clk, .rst_n, .return_stack_head, .stack_pop, .pc_load, .pc_value,
  .interrupt_control_reg, .global_irq_enable, .fetch_flush, .instr_busy, .status_we);

// ---- bench/return_interrupt_option_exec_tb_top.sv ----
// Testbench of the return/option execution block
`timescale 1ns/1ps
module return_interrupt_option_exec_tb_top;
  import riox_pkg::*;
  logic        core_clk = 0, rst_n = 0, instr_valid = 0, file_opt_we = 0, file_interrupt_control_reg_we = 0;
  logic [13:0] instr_word = 0;
  logic [7:0]  accumulator = 0, file_opt_wdata = 0, file_interrupt_control_reg_wdata = 0, option_reg, interrupt_control_reg, d;
  logic [12:0] return_stack_head = 0, pc_value, h;
  logic        stack_pop, pc_load, global_irq_enable, fetch_flush, instr_busy, status_we;
  logic [12:0] exp_q[$];   // Expected return addresses
  int          n_mismatch = 0, tests_run = 0, seed = 32'he8727f66;
  always #2.5 core_clk = ~core_clk;
  riox_exec u_riox_exec (.core_clk, .rst_n, .instr_word, .instr_valid, .accumulator, .return_stack_head,
    .file_opt_we, .file_opt_wdata, .file_interrupt_control_reg_we, .file_interrupt_control_reg_wdata, .stack_pop, .pc_load, .pc_value,
    .option_reg, .interrupt_control_reg, .global_irq_enable, .fetch_flush, .instr_busy, .status_we);
  // Compare and count
  task cmp(string nm, logic [12:0] e, logic [12:0] s);
    tests_run++;
    if (e !== s) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Hold a word n clocks, so at least one phase-one edge sees it
  task run(logic [13:0] w, int n, logic [7:0] a, logic [12:0] hd);
    @(posedge core_clk);
    instr_word <= w; accumulator <= a; return_stack_head <= hd; instr_valid <= 1;
    repeat (n) @(posedge core_clk);
    instr_valid <= 0;
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  // Verdict
  task end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Each pop takes the oldest expected address
  always @(negedge core_clk) begin
    if (stack_pop === 1'b1) begin
      if (exp_q.size() == 0) cmp("stray_pop", 0, 1);
      else cmp("pc_value", exp_q.pop_front(), pc_value);
    end
  end
  // Watchdog
  initial begin
    #5000;
    n_mismatch++;
    end_of_test;
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    #1 cmp("pc_reset", RIOX_PC_RESET, pc_value);
    cmp("option_reset", RIOX_OPTION_RESET, option_reg);
    cmp("icr_reset", RIOX_INTERRUPT_CONTROL_REG_RESET, interrupt_control_reg);
    @(posedge core_clk);
    rst_n <= 1;
    repeat (4) @(posedge core_clk);
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      file_opt_we <= 1; file_opt_wdata <= d; file_interrupt_control_reg_we <= 1; file_interrupt_control_reg_wdata <= d & 8'h7F;
      @(posedge core_clk);
      file_opt_we <= 0; file_interrupt_control_reg_we <= 0;
      @(posedge core_clk);
      #1 cmp("option_file", d, option_reg);
      cmp("irq_enable_clear", 0, global_irq_enable);
      h = $random(seed);
      exp_q.push_back(h);
      run(RIOX_OP_RETURN_FROM_INTERRUPT, 8, d, h);
      cmp("icr", {5'h00, 1'b1, d[6:0]}, interrupt_control_reg);
      d = $random(seed);
      run(RIOX_OP_OPTION_LOAD, 4, d, h);
      cmp("option_load", d, option_reg);
      run(14'h0100 | 14'($random(seed) & 14'h3EFF), 4, ~d, h);
      cmp("option_kept", d, option_reg);
      $display("round %0d done", i);
    end
    repeat (4) @(posedge core_clk);
    cmp("pops_left", 0, 13'(exp_q.size()));
    end_of_test;
  end
endmodule
